//--- design/sas_defines.svh
// offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

`define SAS_ADDR_POWER 16'hFF01
`define SAS_ADDR_CTRL 16'hFFD0
`define SAS_ADDR_PINS 16'hFFD1
`define SAS_ADDR_RES_LO 16'hFFD2
`define SAS_ADDR_RES_HI 16'hFFD3
`define SAS_ADDR_MASK 16'hFFE7
`define SAS_ADDR_FLAG 16'hFFF7

`define SAS_BIT_START 3
`define SAS_BIT_CLKSEL 2
`define SAS_BIT_POWER 3

`define SAS_RST_PINS 4'h0
`define SAS_RST_CHS 2'h0
`define SAS_IRQ_VECTOR 16'h010E

`define SAS_CLK_HZ 50000000
`define SAS_CONV_MIN_NS 10500
`define SAS_CONV_REF_HZ 2000000
`define SAS_CONV_TICKS ((`SAS_CONV_MIN_NS * (`SAS_CONV_REF_HZ / 1000) + 999999) / 1000000)
`define SAS_RES_BITS 8
`define SAS_DELAY_TICKS 2
`define SAS_SAMPLE_TICKS (`SAS_CONV_TICKS - `SAS_DELAY_TICKS - `SAS_RES_BITS - 1)

`define SAS_U_CTRL 3'h0
`define SAS_U_PINS 3'h1
`define SAS_U_MASK 3'h2
`define SAS_U_FLAG 3'h3
`define SAS_U_POWER 3'h4
`define SAS_U_RESULT 3'h5
`define SAS_U_STATUS 3'h6

`endif

//--- design/sas_pkg.sv
// types for the two ends of the converter sequencer: device conversion states and host fetch steps
package sas_pkg;
    typedef enum logic [2:0] {
        SAS_IDLE,
        SAS_DELAY,
        SAS_SAMPLE,
        SAS_CONVERT,
        SAS_LOAD
    } sas_conv_state_t;

    typedef enum logic [1:0] {
        SAS_F_IDLE,
        SAS_F_LO,
        SAS_F_HI,
        SAS_F_FLAG
    } sas_fetch_t;
endpackage

//--- design/sas_if.sv
// i/o memory link between the cpu-side controller and the converter sequencer
interface sas_if;
    logic [15:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
    logic [3:0] rdata;
    logic irq;
    logic [15:0] vector;
    logic busy;

    modport device(input addr, input wdata, input wr, input rd,
                   output rdata, output irq, output vector, output busy);
    modport host(output addr, output wdata, output wr, output rd,
                 input rdata, input irq, input vector, input busy);
endinterface

//--- design/sas_clk_gate.sv
// conversion clock selector: oscillator sync, fast divide by two, start gating
module sas_clk_gate (
    // system
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // oscillator pins
    input wire logic slow_osc,
    input wire logic fast_osc,
    // control
    input wire logic select,
    input wire logic gate,
    // conversion clock tick
    output logic tick
);
    logic [2:0] slow_s_q;
    logic [2:0] fast_s_q;
    logic half_q;
    logic slow_rise;
    logic fast_rise;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_s_q <= 3'h0;
            fast_s_q <= 3'h0;
        end else if (ce) begin
            slow_s_q <= {slow_s_q[1:0], slow_osc};
            fast_s_q <= {fast_s_q[1:0], fast_osc};
        end
    end

    assign slow_rise = slow_s_q[1] & ~slow_s_q[2];
    assign fast_rise = fast_s_q[1] & ~fast_s_q[2];

    // divider runs free so the first gated tick is never a short one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 1'b0;
        end else if (ce && fast_rise) begin
            half_q <= ~half_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else if (ce) begin
            tick <= gate & (select ? (fast_rise & half_q) : slow_rise); // RULE4 RULE5
        end
    end
endmodule // sas_clk_gate

//--- design/sas_device.sv
// successive-approximation converter sequencer with its i/o memory control bits
// Functional notes
// RULE1 - eight-bit result by successive approximation
// RULE2 - each pin analog when its enable is set
// RULE3 - reset clears enables, pins float
// RULE4 - select zero slow clock, one fast/2
// RULE5 - clock passes only after start write
// RULE6 - software changes clock only while idle
// RULE7 - software never starts without delivered clock
// RULE8 - channel field picks input zero to three
// RULE9 - writing start bit begins conversion
// RULE10 - low supply needs booster power selected
// RULE11 - delay, sample, then bitwise conversion
// RULE12 - result loaded, bit zero least significant
// RULE13 - selected channel must be analog enabled
// RULE14 - flag set right after result store
// RULE15 - request only when mask is one
// RULE16 - flag set regardless of mask
// RULE17 - write one clears flag, zero ignored
// RULE18 - completion vector is fixed address
// RULE19 - conversion lasts twenty-one conversion clocks
// RULE20 - start write zero ignored, reads zero
// RULE21 - result undefined until first conversion
// RULE22 - after load stop clock, go idle
// RULE23 - start while busy is ignored
`include "sas_defines.svh"

module sas_device (
    // system
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // oscillator pins
    input wire logic SLOW_OSC_CLOCK,
    input wire logic FAST_OSC_CLOCK,
    // analog front end
    input wire logic COMPARATOR_IN,
    output logic [7:0] DAC_CODE,
    output logic SAMPLE_HOLD,
    output logic [1:0] MUX_SEL,
    output logic [3:0] ANALOG_PIN_ENABLE,
    output logic CONV_POWER_SELECT,
    // cpu side
    sas_if.device bus
);
    localparam logic [3:0] DELAY_LAST = 4'(`SAS_DELAY_TICKS - 1);
    localparam logic [3:0] SAMPLE_LAST = 4'(`SAS_SAMPLE_TICKS - 1);

    sas_pkg::sas_conv_state_t state_q;
    logic [3:0] pad_q;
    logic clksel_q;
    logic [1:0] chs_q;
    logic mask_q;
    logic flag_q;
    logic power_q;
    logic [7:0] result_q;
    logic [7:0] dac_q;
    logic [2:0] bit_idx_q;
    logic [3:0] cnt_q;
    logic sh_q;
    logic [1:0] mux_q;
    logic busy_q;
    logic irq_q;
    logic [3:0] rdata_q;
    logic [15:0] vector_q;
    logic comp_s1_q;
    logic comp_s2_q;
    logic tick;
    logic start_wr;
    logic load_now;

    function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] target,
                                    input logic wr);
        wr_hit = wr && (a == target);
    endfunction

    assign start_wr = wr_hit(bus.addr, `SAS_ADDR_CTRL, bus.wr) && bus.wdata[`SAS_BIT_START];
    assign load_now = (state_q == sas_pkg::SAS_LOAD) && tick;

    sas_clk_gate u_clk_gate (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .slow_osc(SLOW_OSC_CLOCK),
        .fast_osc(FAST_OSC_CLOCK),
        .select(clksel_q),
        .gate(busy_q),
        .tick(tick)
    );

    // comparator comes from the analog side, asynchronous to CLK
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
        end else if (CE) begin
            comp_s1_q <= COMPARATOR_IN;
            comp_s2_q <= comp_s1_q;
        end
    end

    // control bits
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pad_q <= `SAS_RST_PINS; // RULE3
            clksel_q <= 1'b0;
            chs_q <= `SAS_RST_CHS;
            mask_q <= 1'b0;
            power_q <= 1'b0;
        end else if (CE) begin
            if (wr_hit(bus.addr, `SAS_ADDR_PINS, bus.wr)) begin
                pad_q <= bus.wdata; // RULE2
            end
            if (wr_hit(bus.addr, `SAS_ADDR_CTRL, bus.wr)) begin
                clksel_q <= bus.wdata[`SAS_BIT_CLKSEL];
                chs_q <= bus.wdata[1:0];
            end
            if (wr_hit(bus.addr, `SAS_ADDR_MASK, bus.wr)) begin
                mask_q <= bus.wdata[0];
            end
            if (wr_hit(bus.addr, `SAS_ADDR_POWER, bus.wr)) begin
                power_q <= bus.wdata[`SAS_BIT_POWER];
            end
        end
    end

    // conversion sequence: 2 delay + 10 sample + 8 decisions + 1 load ticks
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= sas_pkg::SAS_IDLE;
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
            bit_idx_q <= 3'h0;
            dac_q <= 8'h00;
            sh_q <= 1'b0;
            mux_q <= 2'h0;
        end else if (CE) begin
            unique case (state_q)
                sas_pkg::SAS_IDLE: begin
                    if (start_wr) begin // RULE9 RULE20
                        state_q <= sas_pkg::SAS_DELAY;
                        busy_q <= 1'b1; // RULE5
                        cnt_q <= 4'h0;
                        dac_q <= 8'h00;
                        // chs_q only takes this write at the same edge
                        mux_q <= bus.wdata[1:0]; // RULE8
                    end
                end
                sas_pkg::SAS_DELAY: begin
                    if (tick) begin
                        if (cnt_q == DELAY_LAST) begin // RULE11
                            state_q <= sas_pkg::SAS_SAMPLE;
                            cnt_q <= 4'h0;
                            sh_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                sas_pkg::SAS_SAMPLE: begin
                    if (tick) begin
                        if (cnt_q == SAMPLE_LAST) begin // RULE11 RULE19
                            state_q <= sas_pkg::SAS_CONVERT;
                            sh_q <= 1'b0;
                            bit_idx_q <= 3'h7;
                            dac_q <= 8'h80;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                sas_pkg::SAS_CONVERT: begin
                    // trial bit stands one tick so the comparator settles first
                    if (tick) begin
                        dac_q[bit_idx_q] <= comp_s2_q; // RULE1
                        if (bit_idx_q == 3'h0) begin
                            state_q <= sas_pkg::SAS_LOAD;
                        end else begin
                            dac_q[bit_idx_q - 3'h1] <= 1'b1;
                            bit_idx_q <= bit_idx_q - 3'h1;
                        end
                    end
                end
                sas_pkg::SAS_LOAD: begin
                    if (tick) begin
                        state_q <= sas_pkg::SAS_IDLE; // RULE22
                        busy_q <= 1'b0;
                    end
                end
            endcase
        end
    end
    // RULE23: start_wr is only looked at in the idle state

    // no reset: contents are meaningless until the first load
    always_ff @(posedge CLK) begin
        if (CE && load_now) begin
            result_q <= dac_q; // RULE12 RULE21
        end
    end

    // completion flag, set beats a same-cycle clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_q <= 1'b0;
        end else if (CE) begin
            if (load_now) begin
                flag_q <= 1'b1; // RULE14 RULE16
            end else if (wr_hit(bus.addr, `SAS_ADDR_FLAG, bus.wr) && bus.wdata[0]) begin
                flag_q <= 1'b0; // RULE17
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_q <= 1'b0;
            vector_q <= `SAS_IRQ_VECTOR;
        end else if (CE) begin
            irq_q <= flag_q & mask_q; // RULE15
            vector_q <= `SAS_IRQ_VECTOR; // RULE18
        end
    end

    // read data stands in the cycle after the read strobe
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 4'h0;
        end else if (CE) begin
            rdata_q <= 4'h0;
            if (bus.rd) begin
                unique case (bus.addr)
                    `SAS_ADDR_CTRL: rdata_q <= {1'b0, clksel_q, chs_q}; // RULE20
                    `SAS_ADDR_PINS: rdata_q <= pad_q;
                    `SAS_ADDR_RES_LO: rdata_q <= result_q[3:0];
                    `SAS_ADDR_RES_HI: rdata_q <= result_q[7:4];
                    `SAS_ADDR_MASK: rdata_q <= {3'h0, mask_q};
                    `SAS_ADDR_FLAG: rdata_q <= {3'h0, flag_q};
                    `SAS_ADDR_POWER: rdata_q <= {power_q, 3'h0};
                    default: rdata_q <= 4'h0;
                endcase
            end
        end
    end

    assign bus.rdata = rdata_q;
    assign bus.irq = irq_q;
    assign bus.vector = vector_q;
    assign bus.busy = busy_q;
    assign DAC_CODE = dac_q;
    assign SAMPLE_HOLD = sh_q;
    assign MUX_SEL = mux_q;
    assign ANALOG_PIN_ENABLE = pad_q; // RULE2 RULE3
    assign CONV_POWER_SELECT = power_q;
endmodule // sas_device

//--- design/sas_host.sv
// cpu-side controller: software register port, guarded orders, result fetch
`include "sas_defines.svh"

module sas_host (
    // system
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // software port
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RDATA,
    // board levels
    input wire logic LOW_SUPPLY,
    input wire logic FAST_OSC_ON,
    // interrupt
    output logic CONV_IRQ,
    // converter side
    sas_if.host bus
);
    sas_pkg::sas_fetch_t fetch_q;
    logic [1:0] cap_q;
    logic [1:0] cap_dly_q;
    logic fetch_busy;
    logic [15:0] addr_q;
    logic [3:0] wdata_q;
    logic wr_q;
    logic rd_q;
    logic [1:0] ctrl_sh_q;
    logic clksel_sh_q;
    logic [3:0] pins_sh_q;
    logic mask_sh_q;
    logic power_sh_q;
    logic flag_sh_q;
    logic [7:0] result_sh_q;
    logic refused_q;
    logic busy_prev_q;
    logic irq_q;
    logic [7:0] rdata_q;
    logic [1:0] low_s_q;
    logic [1:0] fast_s_q;
    logic busy_any;
    logic start_req;
    logic start_ok;
    logic [1:0] chs_new;
    logic clksel_new;
    logic to_device;
    logic [15:0] dev_addr;

    function automatic logic [15:0] map_addr(input logic [2:0] a);
        unique case (a)
            `SAS_U_CTRL: map_addr = `SAS_ADDR_CTRL;
            `SAS_U_PINS: map_addr = `SAS_ADDR_PINS;
            `SAS_U_MASK: map_addr = `SAS_ADDR_MASK;
            `SAS_U_FLAG: map_addr = `SAS_ADDR_FLAG;
            `SAS_U_POWER: map_addr = `SAS_ADDR_POWER;
            default: map_addr = 16'h0000;
        endcase
    endfunction

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_s_q <= 2'h0;
            fast_s_q <= 2'h0;
        end else if (CE) begin
            low_s_q <= {low_s_q[0], LOW_SUPPLY};
            fast_s_q <= {fast_s_q[0], FAST_OSC_ON};
        end
    end

    // a start in flight counts as busy until the device reports it
    assign busy_any = bus.busy | (wr_q && addr_q == `SAS_ADDR_CTRL && wdata_q[`SAS_BIT_START]);
    assign chs_new = busy_any ? ctrl_sh_q : WDATA[1:0]; // RULE6
    assign clksel_new = busy_any ? clksel_sh_q : WDATA[`SAS_BIT_CLKSEL]; // RULE6
    assign start_req = WR_STB && ADDR == `SAS_U_CTRL && WDATA[`SAS_BIT_START];
    assign start_ok = !busy_any && pins_sh_q[chs_new] // RULE13
                      && !(low_s_q[1] && !power_sh_q) // RULE10
                      && !(clksel_new && !fast_s_q[1]); // RULE7
    // pending until the last fetched nibble and the flag are captured
    assign fetch_busy = fetch_q != sas_pkg::SAS_F_IDLE || (busy_prev_q && !bus.busy)
                        || cap_q != 2'h0 || cap_dly_q != 2'h0;
    assign dev_addr = map_addr(ADDR);
    assign to_device = WR_STB && dev_addr != 16'h0000;

    // software shadows and refusal flag
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_sh_q <= `SAS_RST_CHS;
            clksel_sh_q <= 1'b0;
            pins_sh_q <= `SAS_RST_PINS;
            mask_sh_q <= 1'b0;
            power_sh_q <= 1'b0;
            refused_q <= 1'b0;
        end else if (CE && WR_STB) begin
            unique case (ADDR)
                `SAS_U_CTRL: begin
                    ctrl_sh_q <= chs_new;
                    clksel_sh_q <= clksel_new;
                    if (start_req && !start_ok) begin
                        refused_q <= 1'b1;
                    end
                end
                `SAS_U_PINS: pins_sh_q <= WDATA[3:0];
                `SAS_U_MASK: mask_sh_q <= WDATA[0];
                `SAS_U_POWER: power_sh_q <= WDATA[0];
                `SAS_U_STATUS: refused_q <= refused_q & ~WDATA[0];
                default: refused_q <= refused_q;
            endcase
        end
    end

    // bus master: software writes first, fetch reads fill idle cycles
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            addr_q <= 16'h0000;
            wdata_q <= 4'h0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            fetch_q <= sas_pkg::SAS_F_IDLE;
            cap_q <= 2'h0;
            busy_prev_q <= 1'b0;
        end else if (CE) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cap_q <= 2'h0;
            busy_prev_q <= bus.busy;
            if (to_device) begin
                wr_q <= 1'b1;
                addr_q <= dev_addr;
                unique case (ADDR)
                    `SAS_U_CTRL: wdata_q <= {start_req && start_ok, clksel_new, chs_new};
                    `SAS_U_POWER: wdata_q <= {WDATA[0], 3'h0};
                    default: wdata_q <= WDATA[3:0];
                endcase
            end else if (fetch_q != sas_pkg::SAS_F_IDLE) begin
                rd_q <= 1'b1;
                unique case (fetch_q)
                    sas_pkg::SAS_F_LO: begin
                        addr_q <= `SAS_ADDR_RES_LO;
                        cap_q <= 2'h1;
                        fetch_q <= sas_pkg::SAS_F_HI;
                    end
                    sas_pkg::SAS_F_HI: begin
                        addr_q <= `SAS_ADDR_RES_HI;
                        cap_q <= 2'h2;
                        fetch_q <= sas_pkg::SAS_F_FLAG;
                    end
                    default: begin
                        addr_q <= `SAS_ADDR_FLAG;
                        cap_q <= 2'h3;
                        fetch_q <= sas_pkg::SAS_F_IDLE;
                    end
                endcase
            end
            if (busy_prev_q && !bus.busy) begin
                fetch_q <= sas_pkg::SAS_F_LO;
            end
        end
    end

    // capture read data; a fetched flag beats a same-cycle software clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            result_sh_q <= 8'h00;
            flag_sh_q <= 1'b0;
            cap_dly_q <= 2'h0;
        end else if (CE) begin
            // read data stands one cycle after the strobe, so capture waits one more
            cap_dly_q <= cap_q;
            if (cap_dly_q == 2'h1) begin
                result_sh_q[3:0] <= bus.rdata;
            end
            if (cap_dly_q == 2'h2) begin
                result_sh_q[7:4] <= bus.rdata;
            end
            if (cap_dly_q == 2'h3 && bus.rdata[0]) begin
                flag_sh_q <= 1'b1; // RULE17
            end else if (WR_STB && ADDR == `SAS_U_FLAG && WDATA[0]) begin
                flag_sh_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else if (CE) begin
            irq_q <= bus.irq; // RULE15
            rdata_q <= 8'h00;
            if (RD_STB) begin
                unique case (ADDR)
                    `SAS_U_CTRL: rdata_q <= {5'h00, clksel_sh_q, ctrl_sh_q};
                    `SAS_U_PINS: rdata_q <= {4'h0, pins_sh_q};
                    `SAS_U_MASK: rdata_q <= {7'h00, mask_sh_q};
                    `SAS_U_FLAG: rdata_q <= {7'h00, flag_sh_q};
                    `SAS_U_POWER: rdata_q <= {7'h00, power_sh_q};
                    `SAS_U_RESULT: rdata_q <= result_sh_q;
                    `SAS_U_STATUS: rdata_q <= {5'h00, fetch_busy, bus.busy, refused_q};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
    assign RDATA = rdata_q;
    assign CONV_IRQ = irq_q;
endmodule // sas_host

//--- tb/sas_check_sva.sv
// link assertions for the converter sequencer
module sas_check (
    // system
    input wire logic CLK,
    input wire logic RST_N,
    // link
    input wire logic [15:0] addr,
    input wire logic [3:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [3:0] rdata,
    input wire logic irq,
    input wire logic [15:0] vector,
    input wire logic busy
);
    logic busy_q, flag_q, start_q;
    logic [15:0] run_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // flag copy lags the set by one cycle; clears follow any flag write of one, busy or idle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_q <= 1'b0;
            flag_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            busy_q <= busy;
            start_q <= wr && addr == 16'hFFD0 && wdata[3] && !busy;
            if (busy_q && !busy) flag_q <= 1'b1;
            else if (wr && addr == 16'hFFF7 && wdata[0]) flag_q <= 1'b0;
        end
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) run_q <= 16'h0000;
        else run_q <= busy ? run_q + 16'h0001 : 16'h0000;
    end
    a_vector_fixed: assert property (vector == 16'h010E)
        else $error("completion vector moved");
    a_rdata_quiet: assert property (!$past(rd) |-> rdata == 4'h0)
        else $error("read data outside its cycle");
    a_start_zero: assert property (wr && addr == 16'hFFD0 && !wdata[3] && !busy |=> !busy)
        else $error("start bit zero began a conversion");
    a_start_runs: assert property (wr && addr == 16'hFFD0 && wdata[3] && !busy |=> busy)
        else $error("start write did not begin a conversion");
    a_busy_cause: assert property ($rose(busy) |-> start_q)
        else $error("conversion began without a start write");
    a_conv_length: assert property ($fell(busy) |-> run_q >= 16'h0015)
        else $error("conversion too short");
    a_flag_read: assert property (rd && addr == 16'hFFF7 |=> rdata == {3'h0, flag_q})
        else $error("completion flag wrong");
    a_irq_rise: assert property ($rose(irq) |-> ($past(busy, 2) && !$past(busy)) ||
        ($past(wr, 2) && $past(addr, 2) == 16'hFFE7))
        else $error("request raised without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr, 2))
        else $error("request dropped without a write");
    a_strobe_excl: assert property (!(wr && rd))
        else $error("read and write together");
endmodule // sas_check

//--- tb/sar_adc_sequencer_test.sv
// self-checking bench joining the controller to the converter sequencer
module sar_adc_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, slow_osc = 1'b0, fast_osc = 1'b0, cmp = 1'b0;
    logic low_supply = 1'b0, fast_on = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, saw_sh = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, dac_code, d;
    logic [1:0] mux_sel;
    logic [3:0] pin_en;
    logic power_sel, sample_hold, conv_irq;
    logic [31:0] seed = 32'h4D39114B;
    int aval [4];
    int bad_count = 0;
    int n_compared = 0;
    sas_if sas_if_i ();
    sas_device sas_device_i (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .SLOW_OSC_CLOCK(slow_osc),
        .FAST_OSC_CLOCK(fast_osc), .COMPARATOR_IN(cmp), .DAC_CODE(dac_code),
        .SAMPLE_HOLD(sample_hold), .MUX_SEL(mux_sel), .ANALOG_PIN_ENABLE(pin_en),
        .CONV_POWER_SELECT(power_sel), .bus(sas_if_i));
    sas_host sas_host_i (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .LOW_SUPPLY(low_supply),
        .FAST_OSC_ON(fast_on), .CONV_IRQ(conv_irq), .bus(sas_if_i));
    sas_check sas_check_i (.CLK(clk), .RST_N(rst_n), .addr(sas_if_i.addr),
        .wdata(sas_if_i.wdata), .wr(sas_if_i.wr), .rd(sas_if_i.rd), .rdata(sas_if_i.rdata),
        .irq(sas_if_i.irq), .vector(sas_if_i.vector), .busy(sas_if_i.busy));
    always #10 clk = ~clk;
    // oscillators kept slow beside clk so the 2-flop sync sees every edge
    always #200 slow_osc = ~slow_osc;
    // off the clk grid so no toggle meets a rising edge
    always #52 fast_osc = ~fast_osc;
    // comparator: held input at or above the trial code
    always @(posedge clk) cmp <= aval[mux_sel] >= int'(dac_code);
    always @(posedge clk) if (sample_hold === 1'b1) saw_sh <= 1'b1;
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int sar(input int v);
        int c;
        c = 0;
        for (int b = 7; b >= 0; b--) if (v >= (c | (1 << b))) c = c | (1 << b);
        return c;
    endfunction
    task automatic finish_test();
        if (bad_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic get(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            get(3'h6, d);
            if (d[2:1] == 2'h0) return;
        end
        bad_count++;
        finish_test();
    endtask
    task automatic refused();
        get(3'h6, d);
        chk({7'h0, d[0]}, 8'h01);
        put(3'h6, 8'h01);
    endtask
    task automatic conv(input logic [1:0] ch, input logic sel, input logic mask);
        seed = step(seed);
        aval[ch] = int'(seed[7:0]);
        put(3'h2, {7'h0, mask});
        saw_sh <= 1'b0;
        put(3'h0, {5'h01, sel, ch});
        repeat (4) @(posedge clk);
        chk({6'h0, mux_sel}, {6'h0, ch});
        wait_idle();
        chk({7'h0, saw_sh}, 8'h01);
        get(3'h5, d);
        chk(d, 8'(sar(aval[ch])));
        get(3'h3, d);
        chk(d, 8'h01);
        chk({7'h0, conv_irq}, {7'h0, mask});
        put(3'h3, 8'h00);
        get(3'h3, d);
        chk(d, 8'h01);
        put(3'h3, 8'h01);
        get(3'h3, d);
        chk(d, 8'h00);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({4'h0, pin_en}, 8'h00);
        put(3'h1, 8'h05);
        repeat (3) @(posedge clk);
        chk({4'h0, pin_en}, 8'h05);
        put(3'h0, 8'h09);
        refused();
        put(3'h1, 8'h0F);
        for (int i = 0; i < 8; i++) conv(2'(i), 1'b0, i[2]);
        put(3'h0, 8'h0C);
        refused();
        fast_on <= 1'b1;
        repeat (3) @(posedge clk);
        conv(2'h3, 1'b1, 1'b1);
        low_supply <= 1'b1;
        repeat (3) @(posedge clk);
        put(3'h0, 8'h08);
        refused();
        put(3'h4, 8'h01);
        repeat (3) @(posedge clk);
        chk({7'h0, power_sel}, 8'h01);
        conv(2'h2, 1'b0, 1'b0);
        put(3'h0, 8'h08);
        repeat (2) @(posedge clk);
        put(3'h0, 8'h09);
        refused();
        wait_idle();
        get(3'h5, d);
        chk(d, 8'(sar(aval[0])));
        put(3'h0, 8'h01);
        repeat (4) @(posedge clk);
        get(3'h6, d);
        chk(d, 8'h00);
        finish_test();
    end
endmodule // sar_adc_sequencer_test
